// [core/tmr_core.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module tmr_core (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    input  wire logic       i_clk_en,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_count_input_pin,
    input  wire logic       i_ext_trigger_pin,
    input  wire logic       i_t1_ovf,
    output logic            o_rx_baud_tick,
    output logic            o_tx_baud_tick,
    output logic            o_overflow_toggle_pin,
    output logic            o_overflow_toggle_oe,
    output logic            o_irq
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [7:0]  pin_mode;
        logic [7:0]  ctl;
        logic [15:0] rcap;
        logic [15:0] cnt;
        logic        pre;
        logic        ovf_q;
        logic        toggle;
        logic [7:0]  rdata;
    } tmr_core_st_t;

    tmr_core_st_t r;
    tmr_core_st_t next_r;

    logic cnt_fall;
    logic trig_fall;
    logic run;
    logic baud;
    logic capture_mode;
    logic inc;
    logic ovf;
    logic trig;
    logic trig_load;
    logic cnt_wr;
    logic rcap_wr;
    logic ctl_wr;

    tmr_evt_if ev ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ==========================================================
    // pin synchronisers
    tmr_edge_sync u_count_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_count_input_pin),
        .o_fall    (cnt_fall)
    );

    tmr_edge_sync u_trig_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_ext_trigger_pin),
        .o_fall    (trig_fall)
    );

    // ==========================================================
    // interrupt status and mask
    tmr_irq u_irq (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .ev        (ev)
    );

    // ==========================================================
    // count control terms
    assign run          = r.ctl[CTL_RUN];
    assign baud         = r.ctl[CTL_RX_SEL] | r.ctl[CTL_TX_SEL];
    assign capture_mode = r.ctl[CTL_CAP_SEL] & ~baud;
    assign inc          = run & (r.ctl[CTL_CT_SEL] ? cnt_fall : r.pre);
    assign ovf          = inc & (r.cnt == CNT_MAX);
    assign trig         = trig_fall & r.ctl[CTL_EXT_EN];
    assign trig_load    = trig & ~capture_mode;
    assign cnt_wr       = i_wr & (hit(i_addr, ADDR_CNT_LO)
                                | hit(i_addr, ADDR_CNT_HI));
    assign rcap_wr      = i_wr & (hit(i_addr, ADDR_RCAP_LO)
                                | hit(i_addr, ADDR_RCAP_HI));
    assign ctl_wr       = i_wr & hit(i_addr, ADDR_CTL);

    assign ev.ovf_evt = ovf & ~baud;
    assign ev.ext_evt = trig;
    assign ev.stat_rd = i_rd & hit(i_addr, ADDR_IRQ_STAT);
    assign ev.mask_wr = i_wr & hit(i_addr, ADDR_IRQ_MASK);
    assign ev.wdata   = i_wdata;

    // ==========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.ovf_q = 1'b0;
        next_r.rdata = BYTE_ZERO;
        if (run && !r.ctl[CTL_CT_SEL])
            next_r.pre = ~r.pre;
        else
            next_r.pre = 1'b0;
        if (inc)
            next_r.cnt = r.cnt + CNT_ONE;
        if (ovf)
        begin
            next_r.ovf_q = 1'b1;
            next_r.toggle = ~r.toggle;
            if (!capture_mode)
                next_r.cnt = r.rcap;
        end
        if (trig_load)
            next_r.cnt = r.rcap;
        if (trig && capture_mode)
            next_r.rcap = r.cnt;
        if (i_wr)
        begin
            if (hit(i_addr, ADDR_PIN_MODE))
                next_r.pin_mode = i_wdata;
            if (hit(i_addr, ADDR_CTL))
                next_r.ctl = i_wdata;
            if (hit(i_addr, ADDR_RCAP_LO))
                next_r.rcap[7:0] = i_wdata;
            if (hit(i_addr, ADDR_RCAP_HI))
                next_r.rcap[15:8] = i_wdata;
            if (hit(i_addr, ADDR_CNT_LO))
                next_r.cnt[7:0] = i_wdata;
            if (hit(i_addr, ADDR_CNT_HI))
                next_r.cnt[15:8] = i_wdata;
        end
        if (ovf && !baud)
            next_r.ctl[CTL_OVF_FLAG] = 1'b1;
        if (trig)
            next_r.ctl[CTL_EXT_FLAG] = 1'b1;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_PIN_MODE: next_r.rdata = r.pin_mode;
                ADDR_CTL:      next_r.rdata = r.ctl;
                ADDR_RCAP_LO:  next_r.rdata = r.rcap[7:0];
                ADDR_RCAP_HI:  next_r.rdata = r.rcap[15:8];
                ADDR_CNT_LO:   next_r.rdata = r.cnt[7:0];
                ADDR_CNT_HI:   next_r.rdata = r.cnt[15:8];
                ADDR_IRQ_STAT: next_r.rdata = {6'h00, ev.status};
                ADDR_IRQ_MASK: next_r.rdata = {6'h00, ev.mask};
                default:       next_r.rdata = BYTE_ZERO;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            r.pin_mode <= PIN_MODE_RESET;
            r.ctl      <= CTL_RESET;
            r.rcap     <= WORD_RESET;
            r.cnt      <= WORD_RESET;
            r.pre      <= 1'b0;
            r.ovf_q    <= 1'b0;
            r.toggle   <= 1'b0;
            r.rdata    <= BYTE_ZERO;
        end
        else if (i_clk_en)
            r <= next_r;
    end

    // ==========================================================
    // outputs
    assign o_rdata = r.rdata;
    assign o_rx_baud_tick = r.ctl[CTL_RX_SEL] ? r.ovf_q : i_t1_ovf;
    assign o_tx_baud_tick = r.ctl[CTL_TX_SEL] ? r.ovf_q : i_t1_ovf;
    assign o_overflow_toggle_pin = r.toggle;
    assign o_overflow_toggle_oe  = r.pin_mode[PIN_TOGGLE_OE];
    assign o_irq = ev.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_ovf_evt;
        i_clk_en && ovf && !cnt_wr && !ctl_wr;
    endsequence

    sequence s_quiet;
        i_clk_en && !cnt_wr && !trig_load;
    endsequence

    property p_rx_src;
        (s_ovf_evt and r.ctl[CTL_RX_SEL]) |=> o_rx_baud_tick;
    endproperty
    a_rx_src: assert property (p_rx_src)
        else $error("receive tick missing after overflow");

    property p_tx_src;
        (i_clk_en && !r.ctl[CTL_TX_SEL] && !ctl_wr)
            |=> (o_tx_baud_tick == i_t1_ovf);
    endproperty
    a_tx_src: assert property (p_tx_src)
        else $error("transmit tick not from timer1");

    property p_timer_step;
        (s_quiet and (run && !r.ctl[CTL_CT_SEL] && !ovf && !ctl_wr))
            ##1 (s_quiet and (!ovf && !ctl_wr))
            |=> (r.cnt == $past(r.cnt, 2) + CNT_ONE);
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer mode did not step once per two clocks");

    property p_counter_step;
        (s_quiet and (run && r.ctl[CTL_CT_SEL] && cnt_fall && !ovf))
            |=> (r.cnt == $past(r.cnt) + CNT_ONE);
    endproperty
    a_counter_step: assert property (p_counter_step)
        else $error("counter mode missed a pin edge");

    property p_capture;
        (i_clk_en && trig && capture_mode && !rcap_wr)
            |=> (r.rcap == $past(r.cnt));
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy count");

    property p_baud_reload;
        (s_ovf_evt and baud) |=> (r.cnt == $past(r.rcap));
    endproperty
    a_baud_reload: assert property (p_baud_reload)
        else $error("baud mode overflow did not reload");

    property p_rcap_read;
        (i_rd && hit(i_addr, ADDR_RCAP_HI) && i_clk_en)
            |=> (o_rdata == $past(r.rcap[15:8]));
    endproperty
    a_rcap_read: assert property (p_rcap_read)
        else $error("reload high byte read wrong");

    property p_cnt_write;
        (i_clk_en && i_wr && hit(i_addr, ADDR_CNT_LO))
            |=> (r.cnt[7:0] == $past(i_wdata));
    endproperty
    a_cnt_write: assert property (p_cnt_write)
        else $error("count low write not loaded");

    property p_toggle;
        s_ovf_evt |=> (o_overflow_toggle_pin
                       != $past(o_overflow_toggle_pin));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle pin did not flip on overflow");

    property p_run_hold;
        (s_quiet and (!run && !ctl_wr)) |=> (r.cnt == $past(r.cnt));
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("count moved while stopped");

    property p_reload;
        (s_ovf_evt and !r.ctl[CTL_CAP_SEL]) |=> (r.cnt == $past(r.rcap));
    endproperty
    a_reload: assert property (p_reload)
        else $error("overflow did not reload count");

    property p_ovf_flag;
        (i_clk_en && ovf && !baud) |=> r.ctl[CTL_OVF_FLAG];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set");

    property p_no_flag_baud;
        (i_clk_en && baud && !ctl_wr && !r.ctl[CTL_OVF_FLAG])
            |=> !r.ctl[CTL_OVF_FLAG];
    endproperty
    a_no_flag_baud: assert property (p_no_flag_baud)
        else $error("overflow flag set in baud mode");

    property p_ext_flag;
        (i_clk_en && trig) |=> r.ctl[CTL_EXT_FLAG];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("trigger flag not set");

    property p_freeze;
        !i_clk_en |=> (r == $past(r));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_rcap_lo_write;
        (i_clk_en && i_wr && hit(i_addr, ADDR_RCAP_LO))
            |=> (r.rcap[7:0] == $past(i_wdata));
    endproperty
    a_rcap_lo_write: assert property (p_rcap_lo_write)
        else $error("reload low write not loaded");

    property p_cnt_hi_read;
        (i_clk_en && i_rd && hit(i_addr, ADDR_CNT_HI))
            |=> (o_rdata == $past(r.cnt[15:8]));
    endproperty
    a_cnt_hi_read: assert property (p_cnt_hi_read)
        else $error("count high byte read wrong");

    property p_trig_reload;
        (i_clk_en && trig_load && !cnt_wr) |=> (r.cnt == $past(r.rcap));
    endproperty
    a_trig_reload: assert property (p_trig_reload)
        else $error("trigger edge did not reload count");

    property p_rdata_idle;
        (i_clk_en && !i_rd) |=> (o_rdata == BYTE_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
endmodule

// [core/tmr_edge_sync.sv]
`timescale 1ns/1ns
module tmr_edge_sync (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    input  wire logic i_pin,
    output logic      o_fall
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [2:0] sh;
        logic       stable;
        logic       fall;
    } tmr_sync_st_t;

    tmr_sync_st_t r;
    tmr_sync_st_t next_r;

    // ==========================================================
    // three-stage sync, change accepted once stages 2 and 3 agree
    always_comb
    begin
        next_r = r;
        next_r.sh = {r.sh[1], r.sh[0], i_pin};
        next_r.fall = 1'b0;
        if ((r.sh[1] == r.sh[2]) && (r.sh[2] != r.stable))
        begin
            next_r.stable = r.sh[2];
            next_r.fall = r.stable;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            r <= '{sh: 3'h7, stable: 1'b1, fall: 1'b0};
        else if (i_clk_en)
            r <= next_r;
    end

    assign o_fall = r.fall;

    property p_fall_pulse;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_clk_en && r.fall) |=> !r.fall;
    endproperty
    a_fall_pulse: assert property (p_fall_pulse)
        else $error("falling edge pulse longer than one step");
endmodule

// [core/tmr_evt_if.sv]
`timescale 1ns/1ns
interface tmr_evt_if;
    logic                     ovf_evt;
    logic                     ext_evt;
    logic                     stat_rd;
    logic                     mask_wr;
    logic [7:0]               wdata;
    logic [tmr_pkg::IRQ_W-1:0] status;
    logic [tmr_pkg::IRQ_W-1:0] mask;
    logic                     irq;

    modport core (
        output ovf_evt,
        output ext_evt,
        output stat_rd,
        output mask_wr,
        output wdata,
        input  status,
        input  mask,
        input  irq
    );

    modport ctrl (
        input  ovf_evt,
        input  ext_evt,
        input  stat_rd,
        input  mask_wr,
        input  wdata,
        output status,
        output mask,
        output irq
    );
endinterface

// [core/tmr_irq.sv]
`timescale 1ns/1ns
module tmr_irq (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    tmr_evt_if.ctrl   ev
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
    } tmr_irq_st_t;

    tmr_irq_st_t r;
    tmr_irq_st_t next_r;

    // ==========================================================
    // sticky status, cleared by read, event wins over clear
    always_comb
    begin
        next_r = r;
        if (ev.stat_rd)
            next_r.status = '0;
        if (ev.mask_wr)
            next_r.mask = ev.wdata[IRQ_W-1:0];
        if (ev.ovf_evt)
            next_r.status[IRQ_OVF] = 1'b1;
        if (ev.ext_evt)
            next_r.status[IRQ_EXT] = 1'b1;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            r <= '0;
        else if (i_clk_en)
            r <= next_r;
    end

    assign ev.status = r.status;
    assign ev.mask   = r.mask;
    assign ev.irq    = |(r.status & r.mask);

    property p_set_wins;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_clk_en && ev.stat_rd && ev.ovf_evt) |=> r.status[IRQ_OVF];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overflow event lost under status read");
endmodule

// [core/tmr_pkg.sv]
package tmr_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_PIN_MODE  = 8'h93;
    localparam logic [7:0] ADDR_CTL       = 8'hc8;
    localparam logic [7:0] ADDR_RCAP_LO   = 8'hca;
    localparam logic [7:0] ADDR_RCAP_HI   = 8'hcb;
    localparam logic [7:0] ADDR_CNT_LO    = 8'hcc;
    localparam logic [7:0] ADDR_CNT_HI    = 8'hcd;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'hce;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'hcf;

    // ==========================================================
    // timer_control fields
    localparam int CTL_OVF_FLAG    = 7;
    localparam int CTL_EXT_FLAG    = 6;
    localparam int CTL_RX_SEL      = 5;
    localparam int CTL_TX_SEL      = 4;
    localparam int CTL_EXT_EN      = 3;
    localparam int CTL_RUN         = 2;
    localparam int CTL_CT_SEL      = 1;
    localparam int CTL_CAP_SEL     = 0;

    // ==========================================================
    // pin_output_mode fields
    localparam int PIN_TOGGLE_OE   = 6;

    // ==========================================================
    // interrupt status and mask fields
    localparam int IRQ_W           = 2;
    localparam int IRQ_OVF         = 0;
    localparam int IRQ_EXT         = 1;

    // ==========================================================
    // reset values and count constants
    localparam logic [7:0]  PIN_MODE_RESET = 8'h05;
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] CNT_ONE        = 16'h0001;

    // ==========================================================
    // timing: system clocks per timer-mode increment
    localparam int TIMER_DIV = 2;

endpackage

// [dv/timer2_reload_capture_counter_bench.sv]
`timescale 1ns/1ns
module timer2_reload_capture_counter_bench;
    import tmr_pkg::*;

    logic        i_sys_clk;
    logic        i_reset;
    logic        i_clk_en;
    logic [7:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        count_pin;
    logic        trig_pin;
    logic        t1_ovf;
    logic        o_rx_baud_tick;
    logic        o_tx_baud_tick;
    logic        o_overflow_toggle_pin;
    logic        o_overflow_toggle_oe;
    logic        o_irq;
    logic        t1_on;
    logic        clr;
    logic        tog;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] nrx;
    logic [15:0] ntx;
    logic [15:0] nt1;
    int          err_count;
    int          checked;

    tmr_core dut_u (
        .i_sys_clk             (i_sys_clk),
        .i_reset               (i_reset),
        .i_clk_en              (i_clk_en),
        .i_addr                (i_addr),
        .i_wdata               (i_wdata),
        .i_wr                  (i_wr),
        .i_rd                  (i_rd),
        .o_rdata               (o_rdata),
        .i_count_input_pin     (count_pin),
        .i_ext_trigger_pin     (trig_pin),
        .i_t1_ovf              (t1_ovf),
        .o_rx_baud_tick        (o_rx_baud_tick),
        .o_tx_baud_tick        (o_tx_baud_tick),
        .o_overflow_toggle_pin (o_overflow_toggle_pin),
        .o_overflow_toggle_oe  (o_overflow_toggle_oe),
        .o_irq                 (o_irq)
    );

    tmr_pins_model pins_u (
        .i_sys_clk   (i_sys_clk),
        .i_t1_on     (t1_on),
        .o_count_pin (count_pin),
        .o_trig_pin  (trig_pin),
        .o_t1_ovf    (t1_ovf)
    );

    // ==========================================================
    // clock and tick counters
    always #2 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk)
    begin
        nrx <= clr ? 16'h0000 : nrx + {15'h0000, o_rx_baud_tick === 1'h1};
        ntx <= clr ? 16'h0000 : ntx + {15'h0000, o_tx_baud_tick === 1'h1};
        nt1 <= clr ? 16'h0000 : nt1 + {15'h0000, t1_ovf};
    end

    // ==========================================================
    // tasks
    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr  <= ad;
        i_wdata <= d;
        i_wr    <= 1'h1;
        @(posedge i_sys_clk);
        i_wr    <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= ad;
        i_rd   <= 1'h1;
        @(posedge i_sys_clk);
        i_rd   <= 1'h0;
        #1;
        d = o_rdata;
    endtask

    task automatic rc(input string nm, input logic [7:0] ad,
                      input logic [7:0] exp);
        logic [7:0] d;
        rd(ad, d);
        check(nm, {8'h00, d}, {8'h00, exp});
    endtask

    task automatic clear_ticks();
        @(posedge i_sys_clk);
        clr <= 1'h1;
        @(posedge i_sys_clk);
        clr <= 1'h0;
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 50 && o_irq !== 1'h1; i++)
            @(posedge i_sys_clk);
        if (o_irq !== 1'h1)
        begin
            err_count++;
            $display("unexpected o_irq: expected 1 seen %b", o_irq);
            summarize();
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        i_sys_clk = 1'h0;
        i_reset   = 1'h1;
        i_clk_en  = 1'h1;
        i_addr    = 8'h00;
        i_wdata   = 8'h00;
        i_wr      = 1'h0;
        i_rd      = 1'h0;
        t1_on     = 1'h0;
        clr       = 1'h1;
        err_count = 0;
        checked   = 0;
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 1'h0;
        clr     <= 1'h0;
        // reset values
        rc("pin_output_mode", ADDR_PIN_MODE, 8'h05);
        rc("timer_control", ADDR_CTL, 8'h00);
        rc("reload_capture_low", ADDR_RCAP_LO, 8'h00);
        rc("reload_capture_high", ADDR_RCAP_HI, 8'h00);
        rc("count_low", ADDR_CNT_LO, 8'h00);
        rc("count_high", ADDR_CNT_HI, 8'h00);
        check("toggle oe", {15'h0000, o_overflow_toggle_oe}, 16'h0000);
        // read/write, stopped count holds, unmapped place
        wr(ADDR_RCAP_LO, 8'h5a);
        wr(ADDR_RCAP_HI, 8'ha5);
        wr(ADDR_CNT_LO, 8'h3c);
        wr(ADDR_CNT_HI, 8'hc3);
        wr(8'h00, 8'hff);
        repeat (10) @(posedge i_sys_clk);
        rc("reload_capture_low", ADDR_RCAP_LO, 8'h5a);
        rc("reload_capture_high", ADDR_RCAP_HI, 8'ha5);
        rc("count_low", ADDR_CNT_LO, 8'h3c);
        rc("count_high", ADDR_CNT_HI, 8'hc3);
        rc("unmapped", 8'h00, 8'h00);
        // timer mode step: reads ten clocks apart
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CTL, 8'h04);
        rd(ADDR_CNT_LO, a);
        repeat (8) @(posedge i_sys_clk);
        rd(ADDR_CNT_LO, b);
        check("timer step", {8'h00, b - a}, 16'h0005);
        wr(ADDR_CTL, 8'h00);
        // baud ticks follow timer1 when selects are clear
        clear_ticks();
        t1_on <= 1'h1;
        repeat (60) @(posedge i_sys_clk);
        t1_on <= 1'h0;
        repeat (3) @(posedge i_sys_clk);
        check("rx ticks", nrx, nt1);
        check("tx ticks", ntx, nt1);
        check("t1 seen", {15'h0000, nt1 != 16'h0000}, 16'h0001);
        // overflow: reload, flag, toggle, masked then unmasked irq
        wr(ADDR_RCAP_LO, 8'hf0);
        wr(ADDR_RCAP_HI, 8'hff);
        wr(ADDR_CNT_LO, 8'hfe);
        wr(ADDR_CNT_HI, 8'hff);
        wr(ADDR_PIN_MODE, 8'h45);
        wr(ADDR_IRQ_MASK, 8'h00);
        tog = o_overflow_toggle_pin;
        wr(ADDR_CTL, 8'h04);
        repeat (20) @(posedge i_sys_clk);
        check("masked irq", {15'h0000, o_irq}, 16'h0000);
        rc("timer_control", ADDR_CTL, 8'h84);
        wr(ADDR_CTL, 8'h00);
        rc("count_high", ADDR_CNT_HI, 8'hff);
        check("toggle", {15'h0000, o_overflow_toggle_pin},
              {15'h0000, ~tog});
        check("toggle oe", {15'h0000, o_overflow_toggle_oe}, 16'h0001);
        wr(ADDR_IRQ_MASK, 8'h01);
        wait_irq();
        rc("irq status", ADDR_IRQ_STAT, 8'h01);
        check("irq cleared", {15'h0000, o_irq}, 16'h0000);
        rc("irq status", ADDR_IRQ_STAT, 8'h00);
        // baud mode: capture select ignored, no overflow flag
        wr(ADDR_RCAP_LO, 8'hfe);
        wr(ADDR_CNT_LO, 8'hfe);
        wr(ADDR_CNT_HI, 8'hff);
        t1_on <= 1'h1;
        wr(ADDR_CTL, 8'h25);
        clear_ticks();
        repeat (40) @(posedge i_sys_clk);
        rc("timer_control", ADDR_CTL, 8'h25);
        check("tx ticks t1", ntx, nt1);
        check("rx ticks", {15'h0000, nrx >= 16'h0008}, 16'h0001);
        wr(ADDR_CTL, 8'h15);
        clear_ticks();
        repeat (40) @(posedge i_sys_clk);
        rc("timer_control", ADDR_CTL, 8'h15);
        wr(ADDR_CTL, 8'h00);
        t1_on <= 1'h0;
        check("rx ticks t1", nrx, nt1);
        check("tx ticks", {15'h0000, ntx >= 16'h0008}, 16'h0001);
        rc("count_high", ADDR_CNT_HI, 8'hff);
        rc("irq status", ADDR_IRQ_STAT, 8'h00);
        // counter mode
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CTL, 8'h06);
        pins_u.pulse(1'b0, 5);
        repeat (10) @(posedge i_sys_clk);
        rc("count_low", ADDR_CNT_LO, 8'h05);
        wr(ADDR_CTL, 8'h00);
        // capture on trigger edge
        wr(ADDR_CNT_LO, 8'hcd);
        wr(ADDR_CNT_HI, 8'hab);
        wr(ADDR_CTL, 8'h09);
        pins_u.pulse(1'b1, 1);
        repeat (10) @(posedge i_sys_clk);
        rc("reload_capture_low", ADDR_RCAP_LO, 8'hcd);
        rc("reload_capture_high", ADDR_RCAP_HI, 8'hab);
        rc("timer_control", ADDR_CTL, 8'h49);
        wr(ADDR_IRQ_MASK, 8'h02);
        @(posedge i_sys_clk);
        check("trigger irq", {15'h0000, o_irq}, 16'h0001);
        rc("irq status", ADDR_IRQ_STAT, 8'h02);
        // reload on trigger edge
        wr(ADDR_CTL, 8'h08);
        wr(ADDR_RCAP_LO, 8'h34);
        wr(ADDR_RCAP_HI, 8'h12);
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        pins_u.pulse(1'b1, 1);
        repeat (10) @(posedge i_sys_clk);
        rc("count_low", ADDR_CNT_LO, 8'h34);
        rc("count_high", ADDR_CNT_HI, 8'h12);
        rc("timer_control", ADDR_CTL, 8'h48);
        // clock enable low freezes the count and drops writes
        wr(ADDR_CTL, 8'h04);
        @(posedge i_sys_clk);
        i_clk_en <= 1'h0;
        wr(ADDR_CNT_HI, 8'h77);
        repeat (10) @(posedge i_sys_clk);
        i_clk_en <= 1'h1;
        wr(ADDR_CTL, 8'h00);
        rc("count_low", ADDR_CNT_LO, 8'h35);
        rc("count_high", ADDR_CNT_HI, 8'h12);
        // toggle output disabled again
        wr(ADDR_PIN_MODE, 8'h05);
        repeat (2) @(posedge i_sys_clk);
        check("toggle oe", {15'h0000, o_overflow_toggle_oe}, 16'h0000);
        // reset in mid-run clears registers
        i_reset <= 1'h1;
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 1'h0;
        rc("count_low", ADDR_CNT_LO, 8'h00);
        rc("reload_capture_high", ADDR_RCAP_HI, 8'h00);
        check("toggle reset", {15'h0000, o_overflow_toggle_pin},
              16'h0000);
        summarize();
    end
endmodule

// [dv/tmr_pins_model.sv]
`timescale 1ns/1ns
// ==========================================================
// far side: count pin, trigger pin, timer1 overflow
module tmr_pins_model (
    input  wire logic i_sys_clk,
    input  wire logic i_t1_on,
    output logic      o_count_pin,
    output logic      o_trig_pin,
    output logic      o_t1_ovf
);
    logic [2:0] t1_div;

    // pins idle high, timer1 quiet
    initial
    begin
        o_count_pin = 1'h1;
        o_trig_pin  = 1'h1;
        o_t1_ovf    = 1'h0;
        t1_div      = 3'h0;
    end

    // ==========================================================
    // timer1 overflow pulse, one clock in five
    always @(posedge i_sys_clk)
    begin
        t1_div   <= (t1_div == 3'h4) ? 3'h0 : t1_div + 3'h1;
        o_t1_ovf <= i_t1_on && (t1_div == 3'h4);
    end

    // ==========================================================
    // falling edges, low four clocks, high five clocks between pulses
    task automatic pulse(input bit trig, input int n);
        repeat (n)
        begin
            @(posedge i_sys_clk);
            if (trig)
                o_trig_pin <= 1'h0;
            else
                o_count_pin <= 1'h0;
            repeat (4) @(posedge i_sys_clk);
            o_trig_pin  <= 1'h1;
            o_count_pin <= 1'h1;
            repeat (4) @(posedge i_sys_clk);
        end
    endtask
endmodule
